//--- core/csei_pkg.sv
package csei_pkg;
    // Register offsets within the event block (byte addresses on the serial register port)
    localparam logic [7:0] CHG_EVT_SET_OFS = 8'h0A;
    localparam logic [7:0] CHG_EVT_CLR_OFS = 8'h0B;
    localparam logic [7:0] CHG_EN_SET_OFS = 8'h0C;
    localparam logic [7:0] CHG_EN_CLR_OFS = 8'h0D;
    localparam logic [7:0] BAT_EVT_SET_OFS = 8'h0E;
    localparam logic [7:0] BAT_EVT_CLR_OFS = 8'h0F;
    localparam logic [7:0] BAT_EN_SET_OFS = 8'h10;
    localparam logic [7:0] BAT_EN_CLR_OFS = 8'h11;
    localparam logic [7:0] BTN_EVT_SET_OFS = 8'h12;
    localparam logic [7:0] BTN_EVT_CLR_OFS = 8'h13;
    localparam logic [7:0] BTN_EN_SET_OFS = 8'h14;
    localparam logic [7:0] BTN_EN_CLR_OFS = 8'h15;
    // Implemented field widths; upper bits read as zero
    localparam int CHG_BITS = 6;
    localparam int BAT_BITS = 3;
    localparam int BTN_BITS = 4;
    localparam int NUM_GROUPS = 3;
    // Group indices
    localparam int GRP_CHG = 0;
    localparam int GRP_BAT = 1;
    localparam int GRP_BTN = 2;
    // Reset values
    localparam logic [7:0] FLAG_RST = 8'h00;
    localparam logic [7:0] ENABLE_RST = 8'h00;
    // Register kind inside a group of four
    typedef enum logic [3:0] {
        CSEI_EVT_SET = 4'b0001,
        CSEI_EVT_CLR = 4'b0010,
        CSEI_EN_SET = 4'b0100,
        CSEI_EN_CLR = 4'b1000
    } csei_kind_e;
endpackage

//--- core/csei_group.sv
`timescale 1ns/10ps
// One event group: sticky flags plus interrupt enables, all set/clear by writing ones
module csei_group
    import csei_pkg::*;
#(
    parameter int WIDTH = 6
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register writes, already decoded to this group
    input wire logic wr_evt_set,
    input wire logic wr_evt_clr,
    input wire logic wr_en_set,
    input wire logic wr_en_clr,
    input wire logic [WIDTH-1:0] wr_data,
    // Hardware event pulses
    input wire logic [WIDTH-1:0] hw_event,
    // State
    output logic [WIDTH-1:0] flags_ff,
    output logic [WIDTH-1:0] enables_ff,
    output logic pending
);
    logic [WIDTH-1:0] nxt_flags;
    logic [WIDTH-1:0] nxt_enables;

    // Set wins over clear, so an event landing on the acknowledge is kept
    always_comb begin
        nxt_flags = flags_ff;
        if (wr_evt_clr) begin
            nxt_flags = nxt_flags & ~wr_data;
        end
        nxt_flags = nxt_flags | hw_event;
        if (wr_evt_set) begin
            nxt_flags = nxt_flags | wr_data;
        end
    end

    always_comb begin
        nxt_enables = enables_ff;
        if (wr_en_set) begin
            nxt_enables = nxt_enables | wr_data;
        end
        if (wr_en_clr) begin
            nxt_enables = nxt_enables & ~wr_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags_ff <= FLAG_RST[WIDTH-1:0];
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enables_ff <= ENABLE_RST[WIDTH-1:0];
        end else begin
            enables_ff <= nxt_enables;
        end
    end

    assign pending = |(flags_ff & enables_ff);
endmodule // csei_group

//--- core/csei_top.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Enable-set ones enable supplement, trickle, constant current, constant voltage irqs.
// - Enable-set ones also enable charge-done and charge-fault irqs.
// - Ones at 0xD disable charger status irqs; flags stay untouched.
// - Offset 0xE holds battery flags; writing ones forces them set.
// - Ones at 0xF clear matching battery flags.
// - Ones at 0x10 enable battery irqs, refill-needed included.
// - Ones at 0x11 disable battery irqs.
// - Button press sets flag at 0x12; writing one forces it.
// - Button release sets its flag; writing one forces it.
// - Hold-to-exit sets its flag; writing one forces it.
// - Watchdog warning sets its flag; writing one forces it.
// - Ones at 0x13 clear button and watchdog flags.
// - Ones at 0x14 enable button and watchdog irqs.
// - Ones at 0x15 disable button irqs.
// - Ones at the charger set register force charger flags.
// - Ones at the charger clear register clear charger flags.
module csei_top
    import csei_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port from the serial interface
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata_ff,
    output logic reg_hit,
    // Charger status event pulses
    input wire logic supplement_mode_event,
    input wire logic trickle_charge_start_event,
    input wire logic const_current_start_event,
    input wire logic const_voltage_start_event,
    input wire logic charge_done_event,
    input wire logic charge_fault_event,
    // Battery event pulses
    input wire logic battery_present_event,
    input wire logic battery_missing_event,
    input wire logic battery_refill_needed_event,
    // Ship-hold button and watchdog event pulses
    input wire logic button_down_event,
    input wire logic button_up_event,
    input wire logic button_hold_exit_event,
    input wire logic watchdog_warning_event,
    // Interrupt
    output logic irq
);
    logic [NUM_GROUPS-1:0] grp_sel;
    logic [3:0] kind;
    logic [NUM_GROUPS-1:0] grp_pend;
    logic [CHG_BITS-1:0] chg_flags;
    logic [CHG_BITS-1:0] chg_en;
    logic [BAT_BITS-1:0] bat_flags;
    logic [BAT_BITS-1:0] bat_en;
    logic [BTN_BITS-1:0] btn_flags;
    logic [BTN_BITS-1:0] btn_en;
    logic [7:0] nxt_rdata;
    logic [CHG_BITS-1:0] chg_hw;
    logic [BAT_BITS-1:0] bat_hw;
    logic [BTN_BITS-1:0] btn_hw;
    logic [CHG_BITS+BAT_BITS+BTN_BITS-1:0] all_flags;
    logic [CHG_BITS+BAT_BITS+BTN_BITS-1:0] all_en;

    // Maps an offset to its register kind within a group of four
    function automatic logic [3:0] kind_of(input logic [7:0] a, input logic [7:0] base);
        logic [7:0] d;
        d = a - base;
        kind_of = 4'h0;
        if (a >= base && d < 8'h04) begin
            kind_of = 4'(4'b0001 << d[1:0]);
        end
    endfunction

    always_comb begin
        grp_sel = '0;
        kind = 4'h0;
        if (kind_of(reg_addr, CHG_EVT_SET_OFS) != 4'h0) begin
            grp_sel[GRP_CHG] = 1'b1;
            kind = kind_of(reg_addr, CHG_EVT_SET_OFS);
        end else if (kind_of(reg_addr, BAT_EVT_SET_OFS) != 4'h0) begin
            grp_sel[GRP_BAT] = 1'b1;
            kind = kind_of(reg_addr, BAT_EVT_SET_OFS);
        end else if (kind_of(reg_addr, BTN_EVT_SET_OFS) != 4'h0) begin
            grp_sel[GRP_BTN] = 1'b1;
            kind = kind_of(reg_addr, BTN_EVT_SET_OFS);
        end
    end

    assign reg_hit = |grp_sel;

    // Writes of zero bits are harmless because every register is set/clear by ones
    csei_group #(.WIDTH(CHG_BITS)) u_chg (
        .clk(clk),
        .rst(rst),
        .wr_evt_set(reg_wr && grp_sel[GRP_CHG] && kind == CSEI_EVT_SET),
        .wr_evt_clr(reg_wr && grp_sel[GRP_CHG] && kind == CSEI_EVT_CLR),
        .wr_en_set(reg_wr && grp_sel[GRP_CHG] && kind == CSEI_EN_SET),
        .wr_en_clr(reg_wr && grp_sel[GRP_CHG] && kind == CSEI_EN_CLR),
        .wr_data(reg_wdata[CHG_BITS-1:0]),
        .hw_event({charge_fault_event, charge_done_event, const_voltage_start_event,
                   const_current_start_event, trickle_charge_start_event,
                   supplement_mode_event}),
        .flags_ff(chg_flags),
        .enables_ff(chg_en),
        .pending(grp_pend[GRP_CHG])
    );

    csei_group #(.WIDTH(BAT_BITS)) u_bat (
        .clk(clk),
        .rst(rst),
        .wr_evt_set(reg_wr && grp_sel[GRP_BAT] && kind == CSEI_EVT_SET),
        .wr_evt_clr(reg_wr && grp_sel[GRP_BAT] && kind == CSEI_EVT_CLR),
        .wr_en_set(reg_wr && grp_sel[GRP_BAT] && kind == CSEI_EN_SET),
        .wr_en_clr(reg_wr && grp_sel[GRP_BAT] && kind == CSEI_EN_CLR),
        .wr_data(reg_wdata[BAT_BITS-1:0]),
        .hw_event({battery_refill_needed_event, battery_missing_event,
                   battery_present_event}),
        .flags_ff(bat_flags),
        .enables_ff(bat_en),
        .pending(grp_pend[GRP_BAT])
    );

    csei_group #(.WIDTH(BTN_BITS)) u_btn (
        .clk(clk),
        .rst(rst),
        .wr_evt_set(reg_wr && grp_sel[GRP_BTN] && kind == CSEI_EVT_SET),
        .wr_evt_clr(reg_wr && grp_sel[GRP_BTN] && kind == CSEI_EVT_CLR),
        .wr_en_set(reg_wr && grp_sel[GRP_BTN] && kind == CSEI_EN_SET),
        .wr_en_clr(reg_wr && grp_sel[GRP_BTN] && kind == CSEI_EN_CLR),
        .wr_data(reg_wdata[BTN_BITS-1:0]),
        .hw_event({watchdog_warning_event, button_hold_exit_event, button_up_event,
                   button_down_event}),
        .flags_ff(btn_flags),
        .enables_ff(btn_en),
        .pending(grp_pend[GRP_BTN])
    );

    assign irq = |grp_pend;

    // Set and clear views of a pair both show the same state
    always_comb begin
        nxt_rdata = 8'h00;
        unique case (1'b1)
            grp_sel[GRP_CHG]: begin
                nxt_rdata = (kind[3] | kind[2]) ? {2'b00, chg_en} : {2'b00, chg_flags};
            end
            grp_sel[GRP_BAT]: begin
                nxt_rdata = (kind[3] | kind[2]) ? {5'b00000, bat_en} : {5'b00000, bat_flags};
            end
            grp_sel[GRP_BTN]: begin
                nxt_rdata = (kind[3] | kind[2]) ? {4'h0, btn_en} : {4'h0, btn_flags};
            end
            default: begin
                nxt_rdata = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata_ff <= nxt_rdata;
        end
    end

    a_irq_follows: assert property (@(posedge clk) disable iff (rst)
        irq == |({chg_flags & chg_en, bat_flags & bat_en, btn_flags & btn_en}))
        else $error("irq does not match enabled flags");

    a_chg_en_set: assert property (@(posedge clk) disable iff (rst)
        reg_wr && reg_addr == CHG_EN_SET_OFS |=> (chg_en & $past(reg_wdata[CHG_BITS-1:0]))
        == $past(reg_wdata[CHG_BITS-1:0]))
        else $error("charger enable set failed");

    a_chg_en_clr: assert property (@(posedge clk) disable iff (rst)
        reg_wr && reg_addr == CHG_EN_CLR_OFS |=> (chg_en & $past(reg_wdata[CHG_BITS-1:0])) == '0
        && (chg_flags & $past(chg_flags)) == $past(chg_flags))
        else $error("charger enable clear failed");

    a_bat_force: assert property (@(posedge clk) disable iff (rst)
        reg_wr && reg_addr == BAT_EVT_SET_OFS |=> (bat_flags & $past(reg_wdata[BAT_BITS-1:0]))
        == $past(reg_wdata[BAT_BITS-1:0]))
        else $error("battery force failed");

    a_bat_ack: assert property (@(posedge clk) disable iff (rst)
        reg_wr && reg_addr == BAT_EVT_CLR_OFS && !battery_present_event
        && !battery_missing_event && !battery_refill_needed_event
        |=> (bat_flags & $past(reg_wdata[BAT_BITS-1:0])) == '0)
        else $error("battery ack failed");

    a_btn_press: assert property (@(posedge clk) disable iff (rst)
        button_down_event |=> btn_flags[0])
        else $error("button press not captured");

    a_btn_en_clr: assert property (@(posedge clk) disable iff (rst)
        reg_wr && reg_addr == BTN_EN_CLR_OFS |=> (btn_en & $past(reg_wdata[BTN_BITS-1:0])) == '0)
        else $error("button enable clear failed");

    a_wdog_held: assert property (@(posedge clk) disable iff (rst)
        watchdog_warning_event ##1 !(reg_wr && reg_addr == BTN_EVT_CLR_OFS) |=> btn_flags[3])
        else $error("watchdog flag lost");

    // Event vectors as the checks see them; a hardware set may mask a clear or a zero write
    assign chg_hw = {charge_fault_event, charge_done_event, const_voltage_start_event,
                     const_current_start_event, trickle_charge_start_event,
                     supplement_mode_event};
    assign bat_hw = {battery_refill_needed_event, battery_missing_event, battery_present_event};
    assign btn_hw = {watchdog_warning_event, button_hold_exit_event, button_up_event,
                     button_down_event};
    assign all_flags = {chg_flags, bat_flags, btn_flags};
    assign all_en = {chg_en, bat_en, btn_en};

    a_chg_done_en: assert property (@(posedge clk) disable iff (rst)
        reg_wr && reg_addr == CHG_EN_SET_OFS && reg_wdata[CHG_BITS-1 -: 2] == 2'b11
        |=> chg_en[CHG_BITS-1 -: 2] == 2'b11)
        else $error("charge done or fault enable failed");

    a_chg_force: assert property (@(posedge clk) disable iff (rst)
        reg_wr && reg_addr == CHG_EVT_SET_OFS
        |=> (chg_flags & $past(reg_wdata[CHG_BITS-1:0])) == $past(reg_wdata[CHG_BITS-1:0]))
        else $error("charger force failed");

    a_chg_ack: assert property (@(posedge clk) disable iff (rst)
        reg_wr && reg_addr == CHG_EVT_CLR_OFS && chg_hw == '0
        |=> (chg_flags & $past(reg_wdata[CHG_BITS-1:0])) == '0)
        else $error("charger ack failed");

    a_bat_en_set: assert property (@(posedge clk) disable iff (rst)
        reg_wr && reg_addr == BAT_EN_SET_OFS |=> (bat_en & $past(reg_wdata[BAT_BITS-1:0]))
        == $past(reg_wdata[BAT_BITS-1:0]))
        else $error("battery enable set failed");

    a_bat_en_clr: assert property (@(posedge clk) disable iff (rst)
        reg_wr && reg_addr == BAT_EN_CLR_OFS |=> (bat_en & $past(reg_wdata[BAT_BITS-1:0])) == '0)
        else $error("battery enable clear failed");

    a_btn_release: assert property (@(posedge clk) disable iff (rst)
        button_up_event |=> btn_flags[1])
        else $error("button release not captured");

    a_btn_exit: assert property (@(posedge clk) disable iff (rst)
        button_hold_exit_event |=> btn_flags[2])
        else $error("hold to exit not captured");

    a_btn_force: assert property (@(posedge clk) disable iff (rst)
        reg_wr && reg_addr == BTN_EVT_SET_OFS
        |=> (btn_flags & $past(reg_wdata[BTN_BITS-1:0])) == $past(reg_wdata[BTN_BITS-1:0]))
        else $error("button force failed");

    a_btn_ack: assert property (@(posedge clk) disable iff (rst)
        reg_wr && reg_addr == BTN_EVT_CLR_OFS && btn_hw == '0
        |=> (btn_flags & $past(reg_wdata[BTN_BITS-1:0])) == '0)
        else $error("button ack failed");

    a_btn_en_set: assert property (@(posedge clk) disable iff (rst)
        reg_wr && reg_addr == BTN_EN_SET_OFS |=> (btn_en & $past(reg_wdata[BTN_BITS-1:0]))
        == $past(reg_wdata[BTN_BITS-1:0]))
        else $error("button enable set failed");

    // Only cycles without hardware events, since those may set flags on their own
    a_zero_write: assert property (@(posedge clk) disable iff (rst)
        reg_wr && reg_wdata == 8'h00 && {chg_hw, bat_hw, btn_hw} == '0
        |=> $stable(all_flags) && $stable(all_en))
        else $error("zero write changed state");

    a_en_hold: assert property (@(posedge clk) disable iff (rst)
        !reg_wr |=> $stable(all_en))
        else $error("enable changed without a write");

    // Flags may only gain bits while the host is not writing
    a_flags_keep: assert property (@(posedge clk) disable iff (rst)
        !reg_wr |=> (all_flags & $past(all_flags)) == $past(all_flags))
        else $error("flag lost without a clear");

    a_rd_flags: assert property (@(posedge clk) disable iff (rst)
        reg_rd && reg_addr == BAT_EVT_CLR_OFS |=> reg_rdata_ff == {5'b00000, $past(bat_flags)})
        else $error("flag read returned wrong data");

    a_rd_enables: assert property (@(posedge clk) disable iff (rst)
        reg_rd && reg_addr == BTN_EN_SET_OFS |=> reg_rdata_ff == {4'h0, $past(btn_en)})
        else $error("enable read returned wrong data");

    a_rd_unmapped: assert property (@(posedge clk) disable iff (rst)
        reg_rd && !reg_hit |=> reg_rdata_ff == 8'h00)
        else $error("unmapped read not zero");

    a_rd_hold: assert property (@(posedge clk) disable iff (rst)
        !reg_rd |=> $stable(reg_rdata_ff))
        else $error("read data moved without a read");

    // No disable here: the point is what reset itself leaves behind
    a_reset_zero: assert property (@(posedge clk)
        rst |-> all_flags == '0 && all_en == '0 && reg_rdata_ff == 8'h00 && !irq)
        else $error("state not cleared by reset");

    a_decode_onehot: assert property (@(posedge clk) disable iff (rst)
        $onehot0(grp_sel) && $onehot0(kind) && reg_hit == (kind != 4'h0))
        else $error("register decode not one-hot");
endmodule // csei_top

//--- verif/csei_host_model.sv
`timescale 1ns/10ps
// Register-port master standing in for the serial interface
module csei_host_model (
    // Clock
    input wire logic clk,
    // Register port
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'hFF;
        reg_wdata = 8'hFF;
    end

    // Called just after a rising edge; idle cycles show inverted address and data
    task automatic drive(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= (w | r) ? a : ~a;
        reg_wdata <= (w | r) ? d : ~d;
    endtask
endmodule // csei_host_model

//--- verif/tb_top.sv
`timescale 1ns/10ps
module tb_top
    import csei_pkg::*;
;
    localparam logic [7:0] MASK [3] = '{8'h3F, 8'h07, 8'h0F};
    logic clk, rst, reg_wr, reg_rd, reg_hit, irq, rd_seen, wr_seen, hit_seen;
    logic [12:0] ev;
    logic [7:0] reg_addr, reg_wdata, reg_rdata_ff;
    logic [7:0] flg [3];
    logic [7:0] ena [3];
    logic [7:0] exp_q [$];
    logic [7:0] irq_q [$];
    logic [7:0] hit_q [$];
    logic [31:0] seed;
    int err_count;
    int compares;

    csei_host_model u_csei_host_model (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));

    csei_top u_csei_top (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
        .reg_hit(reg_hit), .supplement_mode_event(ev[0]), .trickle_charge_start_event(ev[1]),
        .const_current_start_event(ev[2]), .const_voltage_start_event(ev[3]),
        .charge_done_event(ev[4]), .charge_fault_event(ev[5]),
        .battery_present_event(ev[6]), .battery_missing_event(ev[7]),
        .battery_refill_needed_event(ev[8]), .button_down_event(ev[9]),
        .button_up_event(ev[10]), .button_hold_exit_event(ev[11]),
        .watchdog_warning_event(ev[12]), .irq(irq));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
        compares++;
        if (seen !== want) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic stop_test();
        if (err_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic wr_op(input logic [7:0] a, input logic [7:0] d, input logic [12:0] e);
        int g;
        int k;
        logic [7:0] hw [3];
        g = (int'(a) - int'(CHG_EVT_SET_OFS)) / 4;
        k = (int'(a) - int'(CHG_EVT_SET_OFS)) % 4;
        @(posedge clk);
        u_csei_host_model.drive(1'b1, 1'b0, a, d);
        ev <= e;
        @(posedge clk);
        u_csei_host_model.drive(1'b0, 1'b0, a, d);
        ev <= '0;
        hw = '{8'(e[5:0]), 8'(e[8:6]), 8'(e[12:9])};
        if (a >= CHG_EVT_SET_OFS && a <= BTN_EN_CLR_OFS) begin
            if (k == 0) flg[g] |= d & MASK[g];
            if (k == 1) flg[g] &= ~d;
            if (k == 2) ena[g] |= d & MASK[g];
            if (k == 3) ena[g] &= ~d;
        end
        // Clear and hardware event in one cycle: the event wins
        for (int j = 0; j < 3; j++) flg[j] |= hw[j];
        irq_q.push_back(8'(|((flg[0] & ena[0]) | (flg[1] & ena[1]) | (flg[2] & ena[2]))));
    endtask

    task automatic rd_op(input logic [7:0] a);
        int g;
        int k;
        g = (int'(a) - int'(CHG_EVT_SET_OFS)) / 4;
        k = (int'(a) - int'(CHG_EVT_SET_OFS)) % 4;
        @(posedge clk);
        u_csei_host_model.drive(1'b0, 1'b1, a, 8'(xs()));
        if (a >= CHG_EVT_SET_OFS && a <= BTN_EN_CLR_OFS) begin
            exp_q.push_back((k < 2) ? flg[g] : ena[g]);
        end else begin
            exp_q.push_back(8'h00);
        end
        hit_q.push_back(8'(a >= CHG_EVT_SET_OFS && a <= BTN_EN_CLR_OFS));
        @(posedge clk);
        u_csei_host_model.drive(1'b0, 1'b0, a, 8'h00);
    endtask

    // Read data lands on the edge that takes the strobe, so compare half a cycle later
    initial begin
        rd_seen = 1'b0;
        wr_seen = 1'b0;
        hit_seen = 1'b0;
    end
    // Decode is seen while the strobe stands; irq once the write has landed
    always @(posedge clk) begin
        rd_seen <= reg_rd;
        wr_seen <= reg_wr;
        hit_seen <= reg_hit;
    end
    always @(negedge clk) begin
        if (rd_seen === 1'b1) begin
            check(reg_rdata_ff, exp_q.pop_front(), "rdata");
            check(8'(hit_seen), hit_q.pop_front(), "reg_hit");
        end
        if (wr_seen === 1'b1) begin
            check(8'(irq), irq_q.pop_front(), "irq");
        end
    end

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        #600000;
        err_count++;
        stop_test();
    end

    initial begin
        logic [7:0] a;
        logic [7:0] d;
        logic [12:0] e;
        rst = 1'b1;
        ev = '0;
        err_count = 0;
        compares = 0;
        seed = 32'h0000_000B;
        for (int j = 0; j < 3; j++) begin
            flg[j] = '0;
            ena[j] = '0;
        end
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        // Every offset plus one unmapped neighbour on each side
        for (int j = 9; j <= 22; j++) rd_op(8'(j));
        for (int i = 0; i < 400; i++) begin
            a = 8'h09 + 8'(xs() % 14);
            d = 8'(xs());
            e = (xs() % 4 == 0) ? 13'(1 << (xs() % 13)) : '0;
            wr_op(a, d, e);
            rd_op(8'h09 + 8'(xs() % 14));
        end
        // Zero bits must leave flags and enables alone
        for (int j = 10; j <= 21; j++) begin
            wr_op(8'(j), 8'h00, '0);
            rd_op(8'(j));
        end
        // A second reset in mid-run must drop every flag and enable
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int j = 0; j < 3; j++) begin
            flg[j] = '0;
            ena[j] = '0;
        end
        for (int j = 9; j <= 22; j++) rd_op(8'(j));
        stop_test();
    end
endmodule // tb_top
